/* inc/gpio_cfg_pkg.sv */
`default_nettype none
package gpio_cfg_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFS_PA_LATCH = 8'h00;
  localparam logic [7:0] OFS_PA_DIR   = 8'h01;
  localparam logic [7:0] OFS_PA_CFG   = 8'h02;
  localparam logic [7:0] OFS_PB_LATCH = 8'h03;
  localparam logic [7:0] OFS_PB_DIR   = 8'h04;
  localparam logic [7:0] OFS_PC_LATCH = 8'h06;
  localparam logic [7:0] OFS_PC_DIR   = 8'h07;
  localparam logic [7:0] OFS_PC_CFG   = 8'h08;
  localparam logic [7:0] OFS_PD_LATCH = 8'h09;
  localparam logic [7:0] OFS_PD_DIR   = 8'h0A;
  localparam logic [7:0] OFS_PD_CFG   = 8'h0B;
  localparam logic [7:0] OFS_PE_LATCH = 8'h0C;
  localparam logic [7:0] OFS_PE_DIR   = 8'h0D;
  localparam logic [7:0] OFS_PE_CFG   = 8'h0E;
  localparam logic [7:0] OFS_PF_LATCH = 8'h0F;
  localparam logic [7:0] OFS_PF_DIR   = 8'h10;
  localparam logic [7:0] OFS_MISC     = 8'h40;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // Miscellaneous register fields
  localparam int MISC_SENS_A_HI = 7;
  localparam int MISC_SENS_A_LO = 6;
  localparam int MISC_CLK_OUT   = 5;
  localparam int MISC_SENS_D_HI = 4;
  localparam int MISC_SENS_D_LO = 3;
  localparam int MISC_DIV_HI    = 2;
  localparam int MISC_DIV_LO    = 1;
  localparam int MISC_DIV_EN    = 0;
  // Port F: pins that can only pull low
  localparam logic [7:0] PF_TRUE_OD_MASK = 8'h73;
  // Sensitivity encodings
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE     = 2'h1;
  localparam logic [1:0] SENS_FALL     = 2'h2;
  localparam logic [1:0] SENS_BOTH     = 2'h3;
  // CPU clock divide ratios from the 48 MHz reference (half periods)
  localparam logic [7:0] HALF_SA_DEF  = 8'h08; // 3 MHz
  localparam logic [7:0] HALF_SA_00   = 8'h04; // 6 MHz
  localparam logic [7:0] HALF_SA_10   = 8'h10; // 1.5 MHz
  localparam logic [7:0] HALF_SA_01   = 8'h20; // 750 kHz
  localparam logic [7:0] HALF_SA_11   = 8'h40; // 375 kHz
  localparam logic [7:0] HALF_USB_DEF = 8'h04; // 6 MHz
  localparam logic [7:0] HALF_USB_00  = 8'h03; // 8 MHz
  localparam logic [7:0] HALF_USB_10  = 8'h0C; // 2 MHz
  localparam logic [7:0] HALF_USB_01  = 8'h18; // 1 MHz
  localparam logic [7:0] HALF_USB_11  = 8'h60; // 250 kHz

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } pin_drive_type;
endpackage
`default_nettype wire

/* src/gpio_ports.sv */
// Chosen here: the plain strobed port.
`default_nettype none
module gpio_ports
  import gpio_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  // Register port
  input  wire gpio_cfg_pkg::reg_req_type  req,
  output var  logic [7:0]                 rdata,
  // CPU state
  input  wire logic                       irq_level_high_bit,
  input  wire logic                       irq_level_low_bit,
  input  wire logic                       usb_mode,
  input  wire logic                       clk_ref_tick,
  input  wire logic                       vec_fetch_a,
  input  wire logic                       vec_fetch_d,
  // Alternate function claim and drive, per pin of port B
  input  wire logic [7:0]                 alt_claim_b,
  input  wire logic [7:0]                 alt_out_b,
  // Pins, six ports of eight
  input  wire logic [47:0]                pin_in,
  output var  logic [47:0]                pin_out,
  output var  logic [47:0]                pin_oe_n,
  // Interrupts and clock
  output var  logic                       port_a_ext_irq,
  output var  logic                       port_d_ext_irq,
  output var  logic                       cpu_clock_out_enable,
  output var  logic                       cpu_clk_en
);
  import gpio_cfg_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] latch_ff [6];
  logic [7:0] dir_ff [6];
  logic [7:0] cfg_ff [6];
  logic [7:0] misc_ff;
  logic [47:0] pin_sync_ff;
  logic [7:0] in_sync_a1_ff, in_sync_a2_ff, in_sync_d1_ff, in_sync_d2_ff;
  logic grp_a_prev_ff, grp_d_prev_ff;
  logic [7:0] div_cnt_ff;
  logic       clk_phase_ff;
  logic       level3;
  assign level3 = irq_level_high_bit & irq_level_low_bit;

  // Port register writes; latch stored regardless of direction
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int p = 0; p < 6; p++)
      begin
        latch_ff[p] <= REG_RESET;
        dir_ff[p]   <= REG_RESET;
        cfg_ff[p]   <= REG_RESET;
      end
    end
    else if (req.wr)
    begin
      case (req.addr)
        OFS_PA_LATCH: latch_ff[0] <= req.wdata;
        OFS_PA_DIR:   dir_ff[0]   <= req.wdata;
        OFS_PA_CFG:   cfg_ff[0]   <= req.wdata;
        OFS_PB_LATCH: latch_ff[1] <= req.wdata;
        OFS_PB_DIR:   dir_ff[1]   <= req.wdata;
        OFS_PC_LATCH: latch_ff[2] <= req.wdata;
        OFS_PC_DIR:   dir_ff[2]   <= req.wdata;
        OFS_PC_CFG:   cfg_ff[2]   <= req.wdata;
        OFS_PD_LATCH: latch_ff[3] <= req.wdata;
        OFS_PD_DIR:   dir_ff[3]   <= req.wdata;
        OFS_PD_CFG:   cfg_ff[3]   <= req.wdata;
        OFS_PE_LATCH: latch_ff[4] <= req.wdata;
        OFS_PE_DIR:   dir_ff[4]   <= req.wdata;
        OFS_PE_CFG:   cfg_ff[4]   <= req.wdata;
        OFS_PF_LATCH: latch_ff[5] <= req.wdata;
        OFS_PF_DIR:   dir_ff[5]   <= req.wdata;
        default: ;
      endcase
    end
  end

  // Miscellaneous register; sensitivity fields guarded by level 3
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      misc_ff <= REG_RESET;
    else if (req.wr && req.addr == OFS_MISC)
    begin
      misc_ff[MISC_CLK_OUT] <= req.wdata[MISC_CLK_OUT];
      misc_ff[MISC_DIV_HI:MISC_DIV_EN] <= req.wdata[MISC_DIV_HI:MISC_DIV_EN];
      if (level3)
      begin
        misc_ff[MISC_SENS_A_HI:MISC_SENS_A_LO] <=
          req.wdata[MISC_SENS_A_HI:MISC_SENS_A_LO];
        misc_ff[MISC_SENS_D_HI:MISC_SENS_D_LO] <=
          req.wdata[MISC_SENS_D_HI:MISC_SENS_D_LO];
      end
    end
  end

  // Sample pins once; reads see the pin, not the latch
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pin_sync_ff <= '0;
    else
      pin_sync_ff <= pin_in;
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata <= REG_RESET;
    else if (req.rd)
    begin
      case (req.addr)
        OFS_PA_LATCH: rdata <= pin_sync_ff[7:0];
        OFS_PA_DIR:   rdata <= dir_ff[0];
        OFS_PA_CFG:   rdata <= cfg_ff[0];
        OFS_PB_LATCH: rdata <= pin_sync_ff[15:8];
        OFS_PB_DIR:   rdata <= dir_ff[1];
        OFS_PC_LATCH: rdata <= pin_sync_ff[23:16];
        OFS_PC_DIR:   rdata <= dir_ff[2];
        OFS_PC_CFG:   rdata <= cfg_ff[2];
        OFS_PD_LATCH: rdata <= pin_sync_ff[31:24];
        OFS_PD_DIR:   rdata <= dir_ff[3];
        OFS_PD_CFG:   rdata <= cfg_ff[3];
        OFS_PE_LATCH: rdata <= pin_sync_ff[39:32];
        OFS_PE_DIR:   rdata <= dir_ff[4];
        OFS_PE_CFG:   rdata <= cfg_ff[4];
        OFS_PF_LATCH: rdata <= pin_sync_ff[47:40];
        OFS_PF_DIR:   rdata <= dir_ff[5];
        OFS_MISC:     rdata <= misc_ff;
        default:      rdata <= REG_RESET;
      endcase
    end
    else
      rdata <= REG_RESET;
  end

  // ==========================================================
  // Pin drive; per-pin generate. Open-drain output drives low only.
  genvar gp, gb;
  generate
    for (gp = 0; gp < 6; gp++)
    begin : g_port
      for (gb = 0; gb < 8; gb++)
      begin : g_bit
        logic pp, drv_en, val;
        always_comb
        begin
          val = latch_ff[gp][gb];
          if (gp == 1)
            pp = 1'b1;
          else if (gp == 2)
            pp = 1'b1;
          else if (gp == 5)
            pp = ~PF_TRUE_OD_MASK[gb];
          else
            pp = cfg_ff[gp][gb];
          drv_en = dir_ff[gp][gb] & (pp | ~val);
          // Peripheral claim wins over port settings
          if (gp == 1 && alt_claim_b[gb])
          begin
            val = alt_out_b[gb];
            drv_en = 1'b1;
          end
        end
        always_ff @(posedge clk_sys)
        begin
          if (srst)
          begin
            pin_out[gp*8+gb]  <= 1'b0;
            pin_oe_n[gp*8+gb] <= 1'b1;
          end
          else
          begin
            pin_out[gp*8+gb]  <= val;
            pin_oe_n[gp*8+gb] <= ~drv_en;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interrupt groups: two-stage synchronisers first
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      in_sync_a1_ff <= 8'hFF;
      in_sync_a2_ff <= 8'hFF;
      in_sync_d1_ff <= 8'hFF;
      in_sync_d2_ff <= 8'hFF;
    end
    else
    begin
      in_sync_a1_ff <= pin_in[7:0];
      in_sync_a2_ff <= in_sync_a1_ff;
      in_sync_d1_ff <= pin_in[31:24];
      in_sync_d2_ff <= in_sync_d1_ff;
    end
  end
  // Enabled pins combine so a low one masks the rest
  logic grp_a, grp_d;
  assign grp_a = &(in_sync_a2_ff | ~(cfg_ff[0] & ~dir_ff[0]));
  assign grp_d = &(in_sync_d2_ff | ~(cfg_ff[3] & ~dir_ff[3]));

  function automatic logic hit(input logic [1:0] s, input logic cur,
                               input logic prv);
    begin
      case (s)
        SENS_FALL_LOW: hit = ~cur;
        SENS_RISE:     hit = cur & ~prv;
        SENS_FALL:     hit = ~cur & prv;
        SENS_BOTH:     hit = cur ^ prv;
        default:       hit = 1'b0;
      endcase
    end
  endfunction
  logic hit_a, hit_d;
  assign hit_a = hit(misc_ff[MISC_SENS_A_HI:MISC_SENS_A_LO], grp_a,
                     grp_a_prev_ff);
  assign hit_d = hit(misc_ff[MISC_SENS_D_HI:MISC_SENS_D_LO], grp_d,
                     grp_d_prev_ff);

  // Request latch: set wins over vector-fetch clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      grp_a_prev_ff  <= 1'b1;
      grp_d_prev_ff  <= 1'b1;
      port_a_ext_irq <= 1'b0;
      port_d_ext_irq <= 1'b0;
    end
    else
    begin
      grp_a_prev_ff  <= grp_a;
      grp_d_prev_ff  <= grp_d;
      port_a_ext_irq <= hit_a | (port_a_ext_irq & ~vec_fetch_a);
      port_d_ext_irq <= hit_d | (port_d_ext_irq & ~vec_fetch_d);
    end
  end

  // ==========================================================
  // CPU clock prescaler from the 48 MHz reference tick
  logic [7:0] half;
  always_comb
  begin
    case ({usb_mode, misc_ff[MISC_DIV_EN], misc_ff[MISC_DIV_HI:MISC_DIV_LO]})
      4'h0, 4'h1, 4'h2, 4'h3: half = HALF_SA_DEF;
      4'h4: half = HALF_SA_00;
      4'h6: half = HALF_SA_10;
      4'h5: half = HALF_SA_01;
      4'h7: half = HALF_SA_11;
      4'h8, 4'h9, 4'hA, 4'hB: half = HALF_USB_DEF;
      4'hC: half = HALF_USB_00;
      4'hE: half = HALF_USB_10;
      4'hD: half = HALF_USB_01;
      4'hF: half = HALF_USB_11;
      default: half = HALF_SA_DEF;
    endcase
  end

  // Divider; cpu_clk_en pulses once per CPU clock period
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      div_cnt_ff   <= 8'h00;
      clk_phase_ff <= 1'b0;
      cpu_clk_en   <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= 1'b0;
      if (clk_ref_tick)
      begin
        if (div_cnt_ff + 8'h01 >= half)
        begin
          div_cnt_ff   <= 8'h00;
          clk_phase_ff <= ~clk_phase_ff;
          cpu_clk_en   <= clk_phase_ff;
        end
        else
          div_cnt_ff <= div_cnt_ff + 8'h01;
      end
    end
  end

  // Clock-out enable mirrors bit 5
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cpu_clock_out_enable <= 1'b0;
    else
      cpu_clock_out_enable <= misc_ff[MISC_CLK_OUT];
  end

  // ==========================================================
  // Checks
  property p_sens_guard;
    @(posedge clk_sys) disable iff (srst)
    (req.wr && req.addr == OFS_MISC && !level3) |=>
      $stable(misc_ff[MISC_SENS_A_HI:MISC_SENS_A_LO]) &&
      $stable(misc_ff[MISC_SENS_D_HI:MISC_SENS_D_LO]);
  endproperty
  a_sens_guard: assert property (p_sens_guard)
    else $error("sensitivity changed outside level 3");

  property p_latch_write;
    @(posedge clk_sys) disable iff (srst)
    (req.wr && req.addr == OFS_PA_LATCH) |=> latch_ff[0] == $past(req.wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch write lost");

  property p_read_pin;
    @(posedge clk_sys) disable iff (srst)
    (req.rd && req.addr == OFS_PB_LATCH) |=>
      rdata == $past(pin_sync_ff[15:8]);
  endproperty
  a_read_pin: assert property (p_read_pin)
    else $error("latch read not pin level");

  property p_pc_push;
    @(posedge clk_sys) disable iff (srst)
    (dir_ff[2][0]) |=> !pin_oe_n[16];
  endproperty
  a_pc_push: assert property (p_pc_push)
    else $error("port C output not driven");

  property p_pf_od;
    @(posedge clk_sys) disable iff (srst)
    (dir_ff[5][1] && latch_ff[5][1]) |=> pin_oe_n[41];
  endproperty
  a_pf_od: assert property (p_pf_od)
    else $error("port F open-drain drove high");

  property p_input_float;
    @(posedge clk_sys) disable iff (srst)
    (!dir_ff[0][3]) |=> pin_oe_n[3];
  endproperty
  a_input_float: assert property (p_input_float)
    else $error("input pin driven");

  property p_irq_hold;
    @(posedge clk_sys) disable iff (srst)
    (port_a_ext_irq && !vec_fetch_a && !hit_a) |=> port_a_ext_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request dropped without fetch");

  sequence s_fall_a;
    grp_a_prev_ff ##0 !grp_a;
  endsequence
  property p_fall_irq;
    @(posedge clk_sys) disable iff (srst)
    (misc_ff[MISC_SENS_A_HI:MISC_SENS_A_LO] == SENS_FALL) ##0 s_fall_a
      |=> port_a_ext_irq;
  endproperty
  a_fall_irq: assert property (p_fall_irq)
    else $error("falling edge missed");

  property p_mco;
    @(posedge clk_sys) disable iff (srst)
    misc_ff[MISC_CLK_OUT] |=> cpu_clock_out_enable;
  endproperty
  a_mco: assert property (p_mco)
    else $error("clock out not enabled");
endmodule
`default_nettype wire

/* dv/pin_model.sv */
`default_nettype none
// ==========================================================
// Outside world at the pins
module pin_model
(
  // Design drive, low enable means driving
  input  wire logic [47:0] pin_out,
  input  wire logic [47:0] pin_oe_n,
  // Level the outside circuit puts on a released pin
  input  wire logic [47:0] ext_level,
  // Resolved pin levels back to the design
  output var  logic [47:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin follows the outside, never the last driven level
  always_comb
  begin
    for (int i = 0; i < 48; i++)
    begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
// ==========================================================
// Port block bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_cfg_pkg::*;
  // Design ports
  logic        clk_sys;
  logic        srst;
  reg_req_type req;
  logic [7:0]  rdata;
  logic        lvl_hi;
  logic        lvl_lo;
  logic        usb_mode;
  logic        clk_ref_tick;
  logic        vec_a;
  logic        vec_d;
  logic [7:0]  alt_claim;
  logic [7:0]  alt_out;
  logic [47:0] pin_in;
  logic [47:0] pin_out;
  logic [47:0] pin_oe_n;
  logic        irq_a;
  logic        irq_d;
  logic        clk_out_en;
  logic        cpu_clk_en;
  // Bench state
  logic [47:0] ext_level;
  logic [7:0]  la [6];
  logic [7:0]  da [6];
  logic [7:0]  ca [6];
  logic [7:0]  pp0 [6];
  logic [7:0]  half_sa [5];
  logic [7:0]  half_usb [5];
  logic [7:0]  div_sel [5];
  int          n_mismatch;
  int          checked;

  gpio_ports DUT (
    .clk_sys              (clk_sys),
    .srst                 (srst),
    .req                  (req),
    .rdata                (rdata),
    .irq_level_high_bit   (lvl_hi),
    .irq_level_low_bit    (lvl_lo),
    .usb_mode             (usb_mode),
    .clk_ref_tick         (clk_ref_tick),
    .vec_fetch_a          (vec_a),
    .vec_fetch_d          (vec_d),
    .alt_claim_b          (alt_claim),
    .alt_out_b            (alt_out),
    .pin_in               (pin_in),
    .pin_out              (pin_out),
    .pin_oe_n             (pin_oe_n),
    .port_a_ext_irq       (irq_a),
    .port_d_ext_irq       (irq_d),
    .cpu_clock_out_enable (clk_out_en),
    .cpu_clk_en           (cpu_clk_en)
  );

  pin_model pins (
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n),
    .ext_level (ext_level),
    .pin_in    (pin_in)
  );

  // ========================================================
  // Clock, reference tick every other cycle, watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) clk_ref_tick <= ~clk_ref_tick;
  // Longest run is the divider sweep, well under this span
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end

  // ========================================================
  // Tasks
  task automatic cmp(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One write cycle, then one idle cycle so strobes never double up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 v = rdata;
    @(posedge clk_sys);
    cmp($sformatf("rdata_%h", a), e, v);
  endtask
  task automatic fetch;
    vec_a <= 1'b1;
    vec_d <= 1'b1;
    @(posedge clk_sys);
    vec_a <= 1'b0;
    vec_d <= 1'b0;
    wait_clk(5);
  endtask
  // Pin drive follows direction, option and latch of one port
  task automatic chk_port(input int p, input logic [7:0] lat, dir, pp);
    logic [7:0] drv;
    logic [7:0] nd;
    logic [7:0] lvl;
    drv = dir & (pp | ~lat);
    nd = ~drv;
    lvl = (drv & lat) | (nd & ext_level[p*8+:8]);
    cmp("pin_oe_n", nd, pin_oe_n[p*8+:8]);
    cmp("pin_level", lvl, pin_in[p*8+:8]);
    rdchk(la[p], lvl);
  endtask
  task automatic meas(output int n);
    n = 0;
    do @(posedge clk_sys); while (cpu_clk_en !== 1'b1);
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (cpu_clk_en !== 1'b1);
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ========================================================
  // Tests
  initial
  begin
    logic [7:0] e8;
    int n;
    la = '{OFS_PA_LATCH, OFS_PB_LATCH, OFS_PC_LATCH, OFS_PD_LATCH,
           OFS_PE_LATCH, OFS_PF_LATCH};
    da = '{OFS_PA_DIR, OFS_PB_DIR, OFS_PC_DIR, OFS_PD_DIR,
           OFS_PE_DIR, OFS_PF_DIR};
    ca = '{OFS_PA_CFG, 8'h05, OFS_PC_CFG, OFS_PD_CFG, OFS_PE_CFG, 8'h05};
    pp0 = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, ~PF_TRUE_OD_MASK};
    half_sa = '{HALF_SA_DEF, HALF_SA_00, HALF_SA_10, HALF_SA_01,
                HALF_SA_11};
    half_usb = '{HALF_USB_DEF, HALF_USB_00, HALF_USB_10, HALF_USB_01,
                 HALF_USB_11};
    div_sel = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
    n_mismatch = 0;
    checked = 0;
    srst = 1'b1;
    req = '0;
    lvl_hi = 1'b0;
    lvl_lo = 1'b0;
    usb_mode = 1'b0;
    clk_ref_tick = 1'b0;
    vec_a = 1'b0;
    vec_d = 1'b0;
    alt_claim = 8'h00;
    alt_out = 8'h00;
    ext_level = 48'h6996_3CC3_5AA5;
    wait_clk(2);
    srst <= 1'b0;
    @(posedge clk_sys);
    // Reset values and map, unused and unmapped places read zero
    for (int p = 0; p < 6; p++)
    begin
      rdchk(la[p], ext_level[p*8+:8]);
      rdchk(da[p], REG_RESET);
      rdchk(ca[p], REG_RESET);
    end
    wr(8'h05, 8'hFF);
    rdchk(8'h05, 8'h00);
    rdchk(8'h20, 8'h00);
    rdchk(OFS_MISC, REG_RESET);
    $display("test reset_map done");
    // Latch written while input, then both output options
    for (int p = 0; p < 6; p++)
    begin
      wr(la[p], 8'h96);
      wait_clk(3);
      chk_port(p, 8'h96, 8'h00, 8'h00);
      for (int c = 0; c < 2; c++)
      begin
        wr(ca[p], c ? 8'hFF : 8'h00);
        wr(da[p], c ? 8'h5A : 8'hFF);
        wait_clk(3);
        e8 = c ? (p == 5 ? ~PF_TRUE_OD_MASK : 8'hFF) : pp0[p];
        chk_port(p, 8'h96, c ? 8'h5A : 8'hFF, e8);
      end
      wr(da[p], 8'h00);
    end
    $display("test pin_modes done");
    // Peripheral claims two port B pins while they are inputs
    alt_claim <= 8'h81;
    alt_out <= 8'h01;
    wait_clk(4);
    cmp("alt_oe_n", 8'h7E, pin_oe_n[15:8]);
    e8 = 8'h01 | (8'h7E & ext_level[15:8]);
    cmp("alt_level", e8, pin_in[15:8]);
    alt_claim <= 8'h00;
    $display("test alternate done");
    // Sensitivity fields held unless both level bits are set
    wr(OFS_MISC, 8'hFF);
    rdchk(OFS_MISC, 8'h27);
    cmp("clk_out_en", 1'b1, clk_out_en);
    lvl_hi <= 1'b1;
    lvl_lo <= 1'b1;
    wr(OFS_MISC, 8'hD8);
    rdchk(OFS_MISC, 8'hD8);
    cmp("clk_out_en", 1'b0, clk_out_en);
    $display("test misc done");
    // Port A group in every sensitivity, set up only while input
    ext_level[7:0] <= 8'hFF;
    wr(OFS_PA_CFG, 8'hFF);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_MISC, 8'(m << 6));
      fetch();
      cmp("irq_a_idle", 1'b0, irq_a);
      ext_level[0] <= 1'b0;
      wait_clk(5);
      cmp("irq_a_fall", m != 1, irq_a);
      fetch();
      cmp("irq_a_once", m == 0, irq_a);
      ext_level[0] <= 1'b1;
      wait_clk(5);
      cmp("irq_a_rise", m != 2, irq_a);
      fetch();
    end
    $display("test irq_a done");
    // One low pin masks the port D group
    ext_level[31:24] <= 8'hFE;
    wr(OFS_PD_CFG, 8'hFF);
    wr(OFS_MISC, 8'h08);
    fetch();
    ext_level[25] <= 1'b0;
    wait_clk(5);
    ext_level[25] <= 1'b1;
    wait_clk(5);
    cmp("irq_d_masked", 1'b0, irq_d);
    ext_level[24] <= 1'b1;
    wait_clk(5);
    cmp("irq_d_rise", 1'b1, irq_d);
    fetch();
    cmp("irq_d_clear", 1'b0, irq_d);
    $display("test irq_d done");
    // CPU clock period in both modes, every divider setting
    for (int u = 0; u < 2; u++)
      for (int k = 0; k < 5; k++)
      begin
        usb_mode <= u[0];
        wr(OFS_MISC, div_sel[k]);
        meas(n);
        meas(n);
        e8 = u ? half_usb[k] : half_sa[k];
        cmp("cpu_clk_period", {e8, 2'b00}, 16'(n));
      end
    $display("test clock done");
    give_verdict();
  end
endmodule
`default_nettype wire
